// ===== pllcfg_pkg.sv
// pllcfg_pkg.sv: constants, register map and types for the pll path configuration block
// assumes: one 250 MHz clock; registers are 8 bits wide at 8-bit offsets
package pllcfg_pkg;

	// ****************
	// register offsets
	// ****************
	localparam logic [7:0] PLLCFG_ADDR_CP_CURRENT = 8'h0a;
	localparam logic [7:0] PLLCFG_ADDR_VCO_CAL    = 8'h0e;
	localparam logic [7:0] PLLCFG_ADDR_VCO_BAND_R = 8'h0f;
	localparam logic [7:0] PLLCFG_ADDR_BAND_OVR   = 8'h10;
	localparam logic [7:0] PLLCFG_ADDR_FB_INT     = 8'h11;
	localparam logic [7:0] PLLCFG_ADDR_FB_MOD0    = 8'h12;
	localparam logic [7:0] PLLCFG_ADDR_FB_MOD1    = 8'h13;
	localparam logic [7:0] PLLCFG_ADDR_FB_MOD2    = 8'h14;
	localparam logic [7:0] PLLCFG_ADDR_FB_FRAC0   = 8'h15;
	localparam logic [7:0] PLLCFG_ADDR_FB_FRAC1   = 8'h16;
	localparam logic [7:0] PLLCFG_ADDR_FB_FRAC2   = 8'h17;
	localparam logic [7:0] PLLCFG_ADDR_LOAD_CAP   = 8'h1b;
	localparam logic [7:0] PLLCFG_ADDR_IPLL_PATH  = 8'h1d;
	localparam logic [7:0] PLLCFG_ADDR_LF_XTAL    = 8'h33;

	// ****************
	// field positions
	// ****************
	localparam int PLLCFG_BIT_CAL_GO      = 7;
	localparam int PLLCFG_BIT_CAL_BUSY    = 6;
	localparam int PLLCFG_BIT_CAL_SW_EN   = 2;
	localparam int PLLCFG_BIT_BAND_OVR_EN = 0;
	localparam int PLLCFG_BIT_DOUBLER     = 2;
	localparam int PLLCFG_BIT_BYPASS      = 1;
	localparam int PLLCFG_BIT_LF_FAST     = 7;
	localparam int PLLCFG_BIT_HALVER      = 6;
	localparam int PLLCFG_LSB_XTAL_SEL    = 4;

	// ****************
	// reset values
	// ****************
	localparam logic [7:0]  PLLCFG_RST_CP_CURRENT = 8'h80;
	localparam logic [5:0]  PLLCFG_RST_LOAD_CAP   = 6'h08;
	localparam logic [7:0]  PLLCFG_RST_FB_INT     = 8'h40;
	localparam logic [19:0] PLLCFG_RST_FB_MOD     = 20'h00001;
	localparam logic [19:0] PLLCFG_RST_FB_FRAC    = 20'h00000;
	localparam logic [6:0]  PLLCFG_RST_BAND       = 7'h40;
	localparam logic [22:0] PLLCFG_RST_PRBS       = 23'h000001;

	// ****************
	// mode and divider constants
	// ****************
	localparam logic [3:0] PLLCFG_SEL_1944   = 4'h0;
	localparam logic [2:0] PLLCFG_LF_DIV_LAST = 3'h7;
	localparam logic [3:0] PLLCFG_DIV5_BASE  = 4'h5;
	// div-by-five modulator modulus and fraction for each crystal selection
	localparam logic [19:0] PLLCFG_DIV5_MOD [4] = '{20'h003cf, 20'h003cf, 20'h001e6, 20'h003cf};
	localparam logic [19:0] PLLCFG_DIV5_FRAC[4] = '{20'h00100, 20'h00080, 20'h00040, 20'h00010};

	// ****************
	// timing
	// ****************
	localparam int PLLCFG_CLK_MHZ      = 250;
	localparam int PLLCFG_CAL_SETTLE_NS = 1000;
	localparam int PLLCFG_CAL_SETTLE_CYC = (PLLCFG_CAL_SETTLE_NS * PLLCFG_CLK_MHZ) / 1000;

	// ****************
	// types
	// ****************
	typedef enum logic [1:0] {
		PLLCFG_SRC_UNITY,
		PLLCFG_SRC_DOUBLED,
		PLLCFG_SRC_HALVED,
		PLLCFG_SRC_REF_DIRECT
	} pllcfg_src_t;

	typedef logic [19:0] pllcfg_word20_t;

endpackage

// ===== pllcfg_vco_cal.sv
// pllcfg_vco_cal.sv: successive-approximation vco band search over 128 bands
// assumes: start is a one-cycle pulse; vco_fast is already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
module pllcfg_vco_cal (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// control
	input  wire logic       start,
	input  wire logic       vco_fast,
	// result
	output logic            busy,
	output logic [6:0]      band
);
	import pllcfg_pkg::*;

	typedef enum {CAL_IDLE, CAL_SETTLE, CAL_DECIDE} pllcfg_cal_state_t;

	pllcfg_cal_state_t state_reg;
	logic [2:0]        bit_reg;
	logic [15:0]       wait_reg;
	logic [6:0]        band_reg;

	// ****************
	// search sequencer
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= CAL_IDLE;
			bit_reg   <= 3'h6;
			wait_reg  <= 16'h0000;
			band_reg  <= PLLCFG_RST_BAND;
		end else begin
			case (state_reg)
				CAL_IDLE: begin
					if (start) begin
						band_reg  <= 7'h40;
						bit_reg   <= 3'h6;
						wait_reg  <= 16'h0000;
						state_reg <= CAL_SETTLE;
					end
				end
				CAL_SETTLE: begin
					// vco needs time at each trial band before the comparator means anything
					wait_reg <= wait_reg + 16'h0001;
					if (wait_reg == 16'(PLLCFG_CAL_SETTLE_CYC - 1))
						state_reg <= CAL_DECIDE;
				end
				CAL_DECIDE: begin
					if (vco_fast)
						band_reg[bit_reg] <= 1'b0;
					if (bit_reg == 3'h0) begin
						state_reg <= CAL_IDLE;
					end else begin
						band_reg[bit_reg - 3'h1] <= 1'b1;
						bit_reg   <= bit_reg - 3'h1;
						wait_reg  <= 16'h0000;
						state_reg <= CAL_SETTLE;
					end
				end
				default: state_reg <= CAL_IDLE;
			endcase
		end
	end

	assign busy = (state_reg != CAL_IDLE);
	assign band = band_reg;

endmodule
`default_nettype wire

// ===== pllcfg_top.sv
// pllcfg_top.sv: register file and path control of the two-stage clock synthesis path
// assumes: register strobes on clock; pins, clock edges and comparator are asynchronous
// Functional notes
// - static crystal load capacitance set by six-bit code, quarter picofarad per step.
// - loop filter samples at one eighth of the divided reference by default.
// - fast-sampling bit makes loop filter sample at full divided reference rate.
// - frequency selection pins choose normal or 19.44 MHz mode and path setup.
// - normal mode feeds the same signal to feedback and output pll.
// - normal mode without scaling options gives unity path.
// - multiplier bit inserts doubler, divided reference is twice crystal frequency.
// - divider bit inserts halver, divided reference is half crystal frequency.
// - multiplier bit overrides divider bit.
// - 19.44 MHz mode feedback is doubler plus divide-by-five with third-order modulator.
// - divide-by-five modulus comes from two-bit crystal frequency selection.
// - pseudorandom sequence dithers the divide-by-five modulator.
// - 19.44 MHz mode sends halved output, or doubled when multiplier bit set.
// - bypass bit skips the whole input pll.
// - bypass routes synchronised reference to output pll; oscillator keeps running.
// - software sets output pll charge pump current through eight-bit field.
// - one of 128 vco bands, chosen automatically by calibration.
// - writing calibrate bit starts calibration only while software calibration enabled.
// - band override enable uses software band value instead of calibrated band.
// - feedback divides by integer plus fraction over modulus, 8/20/20 bits.
// - input reference modulators held inactive in 19.44 MHz mode.
`timescale 1ns/1ps
`default_nettype none
module pllcfg_top (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// register port
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	// pins and analog status
	input  wire logic [3:0]           freq_sel_pins,
	input  wire logic                 ref_divided_clk,
	input  wire logic                 div5_fb_clk,
	input  wire logic                 vco_fast,
	input  wire logic                 input_sdm_request,
	// crystal oscillator and input pll
	output logic      [5:0]           load_cap_code,
	output logic                      osc_enable,
	output logic                      loop_filter_sample,
	output logic                      mode_1944,
	output logic                      ipll_enable,
	output logic                      doubler_enable,
	output logic                      halver_enable,
	output logic                      div5_enable,
	output logic      [3:0]           div5_ratio,
	output pllcfg_pkg::pllcfg_src_t   ipll_fb_src,
	output pllcfg_pkg::pllcfg_src_t   opll_ref_src,
	output logic                      input_sdm_enable,
	// output pll
	output logic      [7:0]           cp_current,
	output logic      [6:0]           vco_band,
	output logic                      vco_cal_busy,
	output logic      [7:0]           fb_int,
	output pllcfg_pkg::pllcfg_word20_t fb_mod,
	output pllcfg_pkg::pllcfg_word20_t fb_frac
);
	import pllcfg_pkg::*;

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0]  cp_current_reg;
	logic        cal_sw_en_reg;
	logic        band_ovr_en_reg;
	logic [6:0]  band_ovr_reg;
	logic [7:0]  fb_int_reg;
	logic [19:0] fb_mod_reg;
	logic [19:0] fb_frac_reg;
	logic [5:0]  load_cap_reg;
	logic        doubler_sel_reg;
	logic        bypass_reg;
	logic        lf_fast_reg;
	logic        halver_sel_reg;
	logic [1:0]  xtal_sel_reg;
	logic [7:0]  rdata_reg;
	logic        cal_go_reg;
	logic        auto_cal_reg;

	// synchroniser stages: first stage read only by the second
	logic [6:0]  sync1_reg;
	logic [6:0]  sync2_reg;
	logic        ref_prev_reg;
	logic        fb_prev_reg;
	logic        ref_edge;
	logic        fb_edge;
	logic        vco_fast_s;
	logic        mode_1944_s;
	logic [2:0]  lf_count_reg;
	logic        lf_sample_reg;
	logic [22:0] prbs_reg;
	logic [19:0] acc1_reg;
	logic [19:0] acc2_reg;
	logic [19:0] acc3_reg;
	logic        c2_d_reg;
	logic        c3_d_reg;
	logic        c3_dd_reg;
	logic [3:0]  div5_ratio_reg;
	logic [19:0] div5_mod;
	logic [19:0] div5_in;
	logic [20:0] step1;
	logic [20:0] step2;
	logic [20:0] step3;
	logic [6:0]  cal_band;
	logic        cal_busy;
	logic        cal_start;

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end else begin
			sync1_reg <= {freq_sel_pins, ref_divided_clk, div5_fb_clk, vco_fast};
			sync2_reg <= sync1_reg;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			ref_prev_reg <= 1'b0;
			fb_prev_reg  <= 1'b0;
		end else begin
			ref_prev_reg <= sync2_reg[2];
			fb_prev_reg  <= sync2_reg[1];
		end
	end
	assign ref_edge    = sync2_reg[2] & ~ref_prev_reg;
	assign fb_edge     = sync2_reg[1] & ~fb_prev_reg;
	assign vco_fast_s  = sync2_reg[0];
	assign mode_1944_s = (sync2_reg[6:3] == PLLCFG_SEL_1944);

	// ****************************************************************
	// register writes
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			cp_current_reg  <= PLLCFG_RST_CP_CURRENT;
			cal_sw_en_reg   <= 1'b0;
			band_ovr_en_reg <= 1'b0;
			band_ovr_reg    <= PLLCFG_RST_BAND;
			fb_int_reg      <= PLLCFG_RST_FB_INT;
			fb_mod_reg      <= PLLCFG_RST_FB_MOD;
			fb_frac_reg     <= PLLCFG_RST_FB_FRAC;
			load_cap_reg    <= PLLCFG_RST_LOAD_CAP;
			doubler_sel_reg <= 1'b0;
			bypass_reg      <= 1'b0;
			lf_fast_reg     <= 1'b0;
			halver_sel_reg  <= 1'b0;
			xtal_sel_reg    <= 2'h0;
		end else if (reg_write) begin
			case (reg_addr)
				PLLCFG_ADDR_CP_CURRENT: cp_current_reg <= reg_wdata;
				PLLCFG_ADDR_VCO_CAL: begin
					cal_sw_en_reg   <= reg_wdata[PLLCFG_BIT_CAL_SW_EN];
					band_ovr_en_reg <= reg_wdata[PLLCFG_BIT_BAND_OVR_EN];
				end
				PLLCFG_ADDR_BAND_OVR:   band_ovr_reg <= reg_wdata[7:1];
				// integer value is stored as written; values under 64 are the writer's problem
				PLLCFG_ADDR_FB_INT:     fb_int_reg <= reg_wdata;
				PLLCFG_ADDR_FB_MOD0:    fb_mod_reg[7:0] <= reg_wdata;
				PLLCFG_ADDR_FB_MOD1:    fb_mod_reg[15:8] <= reg_wdata;
				PLLCFG_ADDR_FB_MOD2:    fb_mod_reg[19:16] <= reg_wdata[3:0];
				PLLCFG_ADDR_FB_FRAC0:   fb_frac_reg[7:0] <= reg_wdata;
				PLLCFG_ADDR_FB_FRAC1:   fb_frac_reg[15:8] <= reg_wdata;
				PLLCFG_ADDR_FB_FRAC2:   fb_frac_reg[19:16] <= reg_wdata[3:0];
				PLLCFG_ADDR_LOAD_CAP:   load_cap_reg <= reg_wdata[5:0];
				PLLCFG_ADDR_IPLL_PATH: begin
					doubler_sel_reg <= reg_wdata[PLLCFG_BIT_DOUBLER];
					bypass_reg      <= reg_wdata[PLLCFG_BIT_BYPASS];
				end
				PLLCFG_ADDR_LF_XTAL: begin
					lf_fast_reg    <= reg_wdata[PLLCFG_BIT_LF_FAST];
					halver_sel_reg <= reg_wdata[PLLCFG_BIT_HALVER];
					xtal_sel_reg   <= reg_wdata[PLLCFG_LSB_XTAL_SEL +: 2];
				end
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// calibration requests
	// ****************************************************************
	// go is never stored, so a later enable cannot fire a stale request
	always_ff @(posedge clock) begin
		if (reset) begin
			cal_go_reg <= 1'b0;
		end else begin
			cal_go_reg <= reg_write && (reg_addr == PLLCFG_ADDR_VCO_CAL)
				&& reg_wdata[PLLCFG_BIT_CAL_GO] && cal_sw_en_reg;
		end
	end
	// one calibration after reset
	always_ff @(posedge clock) begin
		if (reset) begin
			auto_cal_reg <= 1'b1;
		end else begin
			auto_cal_reg <= 1'b0;
		end
	end
	assign cal_start = cal_go_reg | auto_cal_reg;
	pllcfg_vco_cal u_vco_cal (
		.clock    (clock),
		.reset    (reset),
		.start    (cal_start),
		.vco_fast (vco_fast_s),
		.busy     (cal_busy),
		.band     (cal_band)
	);

	// ****************************************************************
	// register reads
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				PLLCFG_ADDR_CP_CURRENT: rdata_reg <= cp_current_reg;
				PLLCFG_ADDR_VCO_CAL:    rdata_reg <= {1'b0, cal_busy, 3'h0,
					cal_sw_en_reg, 1'b0, band_ovr_en_reg};
				PLLCFG_ADDR_VCO_BAND_R: rdata_reg <= {1'b0, vco_band};
				PLLCFG_ADDR_BAND_OVR:   rdata_reg <= {band_ovr_reg, 1'b0};
				PLLCFG_ADDR_FB_INT:     rdata_reg <= fb_int_reg;
				PLLCFG_ADDR_FB_MOD0:    rdata_reg <= fb_mod_reg[7:0];
				PLLCFG_ADDR_FB_MOD1:    rdata_reg <= fb_mod_reg[15:8];
				PLLCFG_ADDR_FB_MOD2:    rdata_reg <= {4'h0, fb_mod_reg[19:16]};
				PLLCFG_ADDR_FB_FRAC0:   rdata_reg <= fb_frac_reg[7:0];
				PLLCFG_ADDR_FB_FRAC1:   rdata_reg <= fb_frac_reg[15:8];
				PLLCFG_ADDR_FB_FRAC2:   rdata_reg <= {4'h0, fb_frac_reg[19:16]};
				PLLCFG_ADDR_LOAD_CAP:   rdata_reg <= {2'h0, load_cap_reg};
				PLLCFG_ADDR_IPLL_PATH:  rdata_reg <= {5'h00, doubler_sel_reg, bypass_reg, 1'b0};
				PLLCFG_ADDR_LF_XTAL:    rdata_reg <= {lf_fast_reg, halver_sel_reg,
					xtal_sel_reg, 4'h0};
				default:                rdata_reg <= 8'h00;
			endcase
		end
	end
	assign reg_rdata = rdata_reg;
	// ****************************************************************
	// loop filter sample rate
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			lf_count_reg  <= 3'h0;
			lf_sample_reg <= 1'b0;
		end else begin
			lf_sample_reg <= 1'b0;
			if (ref_edge) begin
				lf_count_reg <= lf_count_reg + 3'h1;
				if (lf_fast_reg)
					lf_sample_reg <= 1'b1;
				else if (lf_count_reg == PLLCFG_LF_DIV_LAST)
					lf_sample_reg <= 1'b1;
			end
		end
	end

	assign loop_filter_sample = lf_sample_reg;

	// ****************************************************************
	// path selection
	// ****************************************************************
	always_comb begin
		ipll_fb_src    = PLLCFG_SRC_UNITY;
		opll_ref_src   = PLLCFG_SRC_UNITY;
		doubler_enable = 1'b0;
		halver_enable  = 1'b0;
		div5_enable    = 1'b0;
		if (mode_1944_s) begin
			div5_enable    = 1'b1;
			doubler_enable = 1'b1;
			ipll_fb_src    = PLLCFG_SRC_DOUBLED;
			// no unity option in this mode
			if (doubler_sel_reg) begin
				opll_ref_src = PLLCFG_SRC_DOUBLED;
			end else begin
				opll_ref_src  = PLLCFG_SRC_HALVED;
				halver_enable = 1'b1;
			end
		end else begin
			if (doubler_sel_reg) begin
				ipll_fb_src    = PLLCFG_SRC_DOUBLED;
				doubler_enable = 1'b1;
			end else if (halver_sel_reg) begin
				ipll_fb_src   = PLLCFG_SRC_HALVED;
				halver_enable = 1'b1;
			end else begin
				ipll_fb_src = PLLCFG_SRC_UNITY;
			end
			opll_ref_src = ipll_fb_src;
		end
		if (bypass_reg)
			opll_ref_src = PLLCFG_SRC_REF_DIRECT;
	end

	assign mode_1944        = mode_1944_s;
	assign ipll_enable      = ~bypass_reg;
	assign osc_enable       = 1'b1;
	assign input_sdm_enable = input_sdm_request & ~mode_1944_s;
	assign load_cap_code    = load_cap_reg;

	// ****************************************************************
	// divide-by-five modulator
	// ****************************************************************
	function automatic logic [20:0] acc_step(input logic [19:0] acc,
		input logic [19:0] inc, input logic [19:0] modulus);
		logic [20:0] sum;
		sum = {1'b0, acc} + {1'b0, inc};
		if (sum >= {1'b0, modulus})
			acc_step = {1'b1, 20'(sum - {1'b0, modulus})};
		else
			acc_step = {1'b0, sum[19:0]};
	endfunction
	assign div5_mod = PLLCFG_DIV5_MOD[xtal_sel_reg];
	assign div5_in  = PLLCFG_DIV5_FRAC[xtal_sel_reg] ^ {19'h00000, prbs_reg[0]};
	assign step1    = acc_step(acc1_reg, div5_in, div5_mod);
	assign step2    = acc_step(acc2_reg, step1[19:0], div5_mod);
	assign step3    = acc_step(acc3_reg, step2[19:0], div5_mod);
	// steps once per feedback divider cycle in 19.44 MHz mode; holds in normal mode
	always_ff @(posedge clock) begin
		if (reset) begin
			prbs_reg       <= PLLCFG_RST_PRBS;
			acc1_reg       <= 20'h00000;
			acc2_reg       <= 20'h00000;
			acc3_reg       <= 20'h00000;
			c2_d_reg       <= 1'b0;
			c3_d_reg       <= 1'b0;
			c3_dd_reg      <= 1'b0;
			div5_ratio_reg <= PLLCFG_DIV5_BASE;
		end else if (fb_edge && mode_1944_s) begin
			prbs_reg  <= {prbs_reg[21:0], prbs_reg[22] ^ prbs_reg[17]};
			acc1_reg  <= step1[19:0];
			acc2_reg  <= step2[19:0];
			acc3_reg  <= step3[19:0];
			c2_d_reg  <= step2[20];
			c3_d_reg  <= step3[20];
			c3_dd_reg <= c3_d_reg;
			// third-order noise shaping: c1 + (c2 - c2') + (c3 - 2c3' + c3'')
			div5_ratio_reg <= 4'(PLLCFG_DIV5_BASE + {3'h0, step1[20]} + {3'h0, step2[20]}
				- {3'h0, c2_d_reg} + {3'h0, step3[20]} - {2'h0, c3_d_reg, 1'b0}
				+ {3'h0, c3_dd_reg});
		end
	end
	assign div5_ratio = div5_ratio_reg;

	// ****************************************************************
	// output pll controls
	// ****************************************************************
	assign cp_current   = cp_current_reg;
	assign vco_band     = band_ovr_en_reg ? band_ovr_reg : cal_band;
	assign vco_cal_busy = cal_busy;
	assign fb_int       = fb_int_reg;
	assign fb_mod       = fb_mod_reg;
	assign fb_frac      = fb_frac_reg;
endmodule
`default_nettype wire

// ===== pllcfg_xtal_model.sv
// pllcfg_xtal_model.sv: stand-in for reference, feedback edges and vco comparator
// assumes: bench gates the reference; band settles at once on a new trial value
`timescale 1ns/1ps
`default_nettype none
module pllcfg_xtal_model #(
	parameter int			REF_HALF = 20,
	parameter logic [6:0]	BAND_TARGET = 7'h2b
) (
	// control from the bench
	input wire logic		ref_run,
	input wire logic [6:0]	vco_band,
	// far side signals
	output logic			ref_divided_clk,
	output logic			div5_fb_clk,
	output logic			vco_fast
);
	// ****************
	// reference and comparator
	// ****************
	// whole periods from the start of a run, so a run never ends high
	initial ref_divided_clk = 1'b0;
	always @(posedge ref_run) begin
		while (ref_run) begin
			#(REF_HALF) ref_divided_clk = 1'b1;
			#(REF_HALF) ref_divided_clk = 1'b0;
		end
	end
	assign div5_fb_clk = ref_divided_clk;
	// above target means the trial band must come down
	assign vco_fast = (vco_band > BAND_TARGET);
endmodule
`default_nettype wire

// ===== pllcfg_top_chk.sv
// pllcfg_top_chk.sv: port checker for pllcfg_top
// assumes: bound to pllcfg_top; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module pllcfg_top_chk (
	// clock and register port
	input wire logic						clock,
	input wire logic						reset,
	input wire logic						reg_write,
	input wire logic [7:0]					reg_addr,
	input wire logic [7:0]					reg_wdata,
	input wire logic						input_sdm_request,
	// design outputs
	input wire logic						osc_enable,
	input wire logic						loop_filter_sample,
	input wire logic						mode_1944,
	input wire logic						ipll_enable,
	input wire logic						doubler_enable,
	input wire logic						halver_enable,
	input wire logic						div5_enable,
	input wire pllcfg_pkg::pllcfg_src_t	ipll_fb_src,
	input wire pllcfg_pkg::pllcfg_src_t	opll_ref_src,
	input wire logic						input_sdm_enable,
	input wire logic [7:0]					cp_current,
	input wire logic [5:0]					load_cap_code,
	input wire logic						vco_cal_busy
);
	import pllcfg_pkg::*;
	// ****************
	// assertions
	// ****************
	logic cal_en_reg;
	// stored enable: a write may not enable and start at once
	always_ff @(posedge clock) begin
		if (reset)
			cal_en_reg <= 1'b0;
		else if (reg_write && reg_addr == PLLCFG_ADDR_VCO_CAL)
			cal_en_reg <= reg_wdata[PLLCFG_BIT_CAL_SW_EN];
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	chk_osc_running: assert property (osc_enable)
		else $error("oscillator stopped");
	chk_sdm_gate: assert property (input_sdm_enable == (input_sdm_request && !mode_1944))
		else $error("input modulator gate wrong");
	chk_bypass_route: assert property (!ipll_enable |-> opll_ref_src == PLLCFG_SRC_REF_DIRECT)
		else $error("bypass route wrong");
	chk_normal_same: assert property (!mode_1944 && ipll_enable |-> opll_ref_src == ipll_fb_src)
		else $error("normal mode sources differ");
	chk_dbl_priority: assert property (!mode_1944 && doubler_enable |-> !halver_enable)
		else $error("halver beside doubler");
	chk_no_unity: assert property (mode_1944 |-> opll_ref_src != PLLCFG_SRC_UNITY)
		else $error("unity path in 19.44 mode");
	chk_div5_mode: assert property (mode_1944 && ipll_enable |-> div5_enable)
		else $error("divide by five off");
	chk_cp_write: assert property (reg_write && reg_addr == PLLCFG_ADDR_CP_CURRENT
		|=> cp_current == $past(reg_wdata))
		else $error("charge pump not written");
	chk_cap_write: assert property (reg_write && reg_addr == PLLCFG_ADDR_LOAD_CAP
		|=> {2'h0, load_cap_code} == ($past(reg_wdata) & 8'h3f))
		else $error("load cap not written");
	chk_cal_start: assert property (reg_write && reg_addr == PLLCFG_ADDR_VCO_CAL
		&& cal_en_reg && reg_wdata[PLLCFG_BIT_CAL_GO] && !vco_cal_busy |-> ##2 vco_cal_busy)
		else $error("calibration did not start");
	chk_lf_pulse: assert property (loop_filter_sample |=> !loop_filter_sample)
		else $error("sample pulse too long");
	cover property (vco_cal_busy ##1 !vco_cal_busy);
	cover property (mode_1944 && ipll_enable);
	cover property (loop_filter_sample);
endmodule
`default_nettype wire

// ===== test_pll_path_configuration.sv
// test_pll_path_configuration.sv: self-checking bench for pllcfg_top
// assumes: pllcfg_xtal_model stands for crystal, reference and vco comparator
`timescale 1ns/1ps
`default_nettype none
module test_pll_path_configuration;
	import pllcfg_pkg::*;
	// ****************
	// signals and instances
	// ****************
	localparam logic [6:0] BAND_TARGET = 7'h2b;
	logic clock, reset, reg_write, reg_read, ref_run, input_sdm_request;
	logic [7:0] reg_addr, reg_wdata;
	logic [3:0] freq_sel_pins;
	wire logic [7:0] reg_rdata, cp_current, fb_int;
	wire logic [6:0] vco_band;
	wire logic [5:0] load_cap_code;
	wire logic ref_divided_clk, div5_fb_clk, vco_fast, vco_cal_busy;
	wire logic mode_1944, input_sdm_enable, div5_enable, loop_filter_sample;
	wire pllcfg_src_t ipll_fb_src, opll_ref_src;
	wire pllcfg_word20_t fb_mod;
	int error_cnt = 0;
	int compares = 0;
	pllcfg_top dut_u (
		.clock, .reset, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
		.freq_sel_pins, .ref_divided_clk, .div5_fb_clk, .vco_fast, .input_sdm_request,
		.load_cap_code, .osc_enable(), .loop_filter_sample, .mode_1944, .ipll_enable(),
		.doubler_enable(), .halver_enable(), .div5_enable, .div5_ratio(), .ipll_fb_src,
		.opll_ref_src, .input_sdm_enable, .cp_current, .vco_band, .vco_cal_busy,
		.fb_int, .fb_mod, .fb_frac()
	);
	pllcfg_xtal_model #(.BAND_TARGET(BAND_TARGET)) model_u (
		.ref_run, .vco_band, .ref_divided_clk, .div5_fb_clk, .vco_fast
	);
	initial clock = 1'b0;
	always #2 clock = ~clock;
	// ****************
	// tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_write = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(negedge clock);
		reg_read = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_read = 1'b0;
		chk(nm, e, reg_rdata);
	endtask
	task automatic pth(input logic [7:0] p, input logic [7:0] x,
		input pllcfg_src_t o, input pllcfg_src_t f);
		wr(PLLCFG_ADDR_IPLL_PATH, p);
		wr(PLLCFG_ADDR_LF_XTAL, x);
		chk("output pll source", o, opll_ref_src);
		chk("feedback source", f, ipll_fb_src);
	endtask
	// 16 periods; stop lands mid-period, clear of a race
	task automatic lf(input logic [7:0] x, input int e);
		int n;
		n = 0;
		wr(PLLCFG_ADDR_LF_XTAL, x);
		ref_run = 1'b1;
		for (int i = 0; i < 170; i++) begin
			@(negedge clock);
			if (i == 157) ref_run = 1'b0;
			n += int'(loop_filter_sample);
		end
		chk("sample pulses", e, n);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 3000 && vco_cal_busy !== 1'b0; i++) @(negedge clock);
		chk("cal busy", 1'b0, vco_cal_busy);
	endtask
	task automatic end_sim;
		$display("compares %0d, error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_regs;
		rdc(PLLCFG_ADDR_CP_CURRENT, 8'h80, "cp reset");
		rdc(PLLCFG_ADDR_LOAD_CAP, 8'h08, "load cap reset");
		rdc(8'h01, 8'h00, "unmapped read");
		wr(PLLCFG_ADDR_CP_CURRENT, 8'h19);
		chk("cp_current", 8'h19, cp_current);
		wr(PLLCFG_ADDR_LOAD_CAP, 8'hff);
		chk("load_cap_code", 6'h3f, load_cap_code);
		wr(PLLCFG_ADDR_FB_MOD0, 8'h45);
		wr(PLLCFG_ADDR_FB_MOD1, 8'h23);
		wr(PLLCFG_ADDR_FB_MOD2, 8'hf1);
		chk("fb_mod", 20'h12345, fb_mod);
		wr(PLLCFG_ADDR_FB_INT, 8'h64);
		chk("fb_int", 8'h64, fb_int);
		$display("t_regs done");
	endtask
	task automatic t_paths;
		pth(8'h00, 8'h00, PLLCFG_SRC_UNITY, PLLCFG_SRC_UNITY);
		pth(8'h04, 8'h00, PLLCFG_SRC_DOUBLED, PLLCFG_SRC_DOUBLED);
		pth(8'h00, 8'h40, PLLCFG_SRC_HALVED, PLLCFG_SRC_HALVED);
		pth(8'h04, 8'h40, PLLCFG_SRC_DOUBLED, PLLCFG_SRC_DOUBLED);
		pth(8'h02, 8'h00, PLLCFG_SRC_REF_DIRECT, PLLCFG_SRC_UNITY);
		freq_sel_pins = PLLCFG_SEL_1944;
		repeat (5) @(negedge clock);
		chk("mode_1944", 1'b1, mode_1944);
		chk("input_sdm_enable", 1'b0, input_sdm_enable);
		pth(8'h00, 8'h00, PLLCFG_SRC_HALVED, PLLCFG_SRC_DOUBLED);
		chk("div5_enable", 1'b1, div5_enable);
		pth(8'h04, 8'h00, PLLCFG_SRC_DOUBLED, PLLCFG_SRC_DOUBLED);
		freq_sel_pins = 4'h1;
		pth(8'h00, 8'h00, PLLCFG_SRC_UNITY, PLLCFG_SRC_UNITY);
		chk("input_sdm_enable", 1'b1, input_sdm_enable);
		$display("t_paths done");
	endtask
	task automatic t_lf;
		lf(8'h00, 2);
		lf(8'h80, 16);
		$display("t_lf done");
	endtask
	task automatic t_cal;
		wait_idle();
		chk("calibrated band", BAND_TARGET, vco_band);
		wr(PLLCFG_ADDR_VCO_CAL, 8'h80);
		repeat (3) @(negedge clock);
		chk("cal refused", 1'b0, vco_cal_busy);
		wr(PLLCFG_ADDR_VCO_CAL, 8'h04);
		wr(PLLCFG_ADDR_VCO_CAL, 8'h84);
		repeat (2) @(negedge clock);
		chk("cal started", 1'b1, vco_cal_busy);
		wait_idle();
		repeat (10) @(negedge clock);
		chk("cal once", 1'b0, vco_cal_busy);
		wr(PLLCFG_ADDR_BAND_OVR, 8'ha4);
		wr(PLLCFG_ADDR_VCO_CAL, 8'h05);
		chk("override band", 7'h52, vco_band);
		wr(PLLCFG_ADDR_VCO_CAL, 8'h04);
		chk("calibrated band", BAND_TARGET, vco_band);
		$display("t_cal done");
	endtask
	initial begin
		reset = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		freq_sel_pins = 4'h1;
		input_sdm_request = 1'b1;
		ref_run = 1'b0;
		repeat (20) @(negedge clock);
		reset = 1'b0;
		t_regs();
		t_paths();
		t_lf();
		t_cal();
		end_sim();
	end
	// far above two calibration runs
	initial begin
		#100000;
		error_cnt++;
		$display("watchdog expired");
		end_sim();
	end
endmodule
bind pllcfg_top pllcfg_top_chk chk_u (
	.clock, .reset, .reg_write, .reg_addr, .reg_wdata, .input_sdm_request,
	.osc_enable, .loop_filter_sample, .mode_1944, .ipll_enable, .doubler_enable,
	.halver_enable, .div5_enable, .ipll_fb_src, .opll_ref_src, .input_sdm_enable,
	.cp_current, .load_cap_code, .vco_cal_busy
);
`default_nettype wire
